/* File: rtl/cet_pkg.sv */
package cet_pkg;

	localparam int unsigned CET_AW = 4;
	localparam int unsigned CET_DW = 8;
	localparam int unsigned CET_TW = 16;

	localparam logic [CET_AW-1:0] CET_ADDR_CTRL = 4'h0;
	localparam logic [CET_AW-1:0] CET_ADDR_SRC = 4'h1;
	localparam logic [CET_AW-1:0] CET_ADDR_VAL_LOW = 4'h2;
	localparam logic [CET_AW-1:0] CET_ADDR_VAL_HIGH = 4'h3;
	localparam logic [CET_AW-1:0] CET_ADDR_IRQ_STAT = 4'h4;
	localparam logic [CET_AW-1:0] CET_ADDR_IRQ_CLR = 4'h5;
	localparam logic [CET_AW-1:0] CET_ADDR_IRQ_EN = 4'h6;
	localparam logic [CET_AW-1:0] CET_ADDR_PIN = 4'h7;

	localparam int unsigned CET_CTRL_MODE_LSB = 0;
	localparam int unsigned CET_CTRL_EN_BIT = 7;
	localparam int unsigned CET_IRQ_CAP_BIT = 0;
	localparam int unsigned CET_PIN_LATCH_BIT = 0;
	localparam int unsigned CET_PIN_DIR_BIT = 1;

	localparam logic [3:0] CET_MODE_ANY = 4'h0;
	localparam logic [3:0] CET_MODE_FALL = 4'h1;
	localparam logic [3:0] CET_MODE_RISE = 4'h2;
	localparam logic [3:0] CET_MODE_RISE4 = 4'h3;
	localparam logic [3:0] CET_MODE_RISE16 = 4'h4;

	localparam logic [4:0] CET_DIV4 = 5'h04;
	localparam logic [4:0] CET_DIV16 = 5'h10;

	localparam logic [1:0] CET_SRC_PIN = 2'h0;
	localparam logic [1:0] CET_SRC_CMP1 = 2'h1;
	localparam logic [1:0] CET_SRC_CMP2 = 2'h2;
	localparam logic [1:0] CET_SRC_CHG = 2'h3;

	localparam logic [7:0] CET_RST_CTRL = 8'h00;
	localparam logic [1:0] CET_RST_SRC = 2'h0;
	localparam logic [7:0] CET_RST_IRQ_EN = 8'h00;
	localparam logic CET_RST_LATCH = 1'b0;
	localparam logic CET_RST_DIR_IN = 1'b1;
	localparam logic [CET_DW-1:0] CET_RD_ZERO = 8'h00;

	typedef struct packed {
		logic en;
		logic [3:0] mode;
	} cet_ctrl_t;

	typedef struct packed {
		logic [CET_DW-1:0] high;
		logic [CET_DW-1:0] low;
	} cet_value_t;

endpackage : cet_pkg

/* File: rtl/cet_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module cet_edge
	import cet_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_level,
	output logic o_rise,
	output logic o_fall
);

	logic prev_q;

	// Previous sample of the selected input
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= i_level;
		end
	end

	assign o_rise = i_level & ~prev_q;
	assign o_fall = ~i_level & prev_q;

endmodule : cet_edge
`default_nettype wire

/* File: rtl/cet_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
module cet_prescale
	import cet_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clr,
	input wire logic i_tick,
	input wire logic [4:0] i_div,
	output logic o_hit
);

	logic [4:0] cnt_q;
	logic [4:0] cnt_d;

	assign o_hit = i_tick & (cnt_q == i_div - 5'h01);

	always_comb begin
		cnt_d = cnt_q;
		if (i_clr) begin
			cnt_d = 5'h00;
		end else if (o_hit) begin
			cnt_d = 5'h00;
		end else if (i_tick) begin
			cnt_d = cnt_q + 5'h01;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : cet_prescale
`default_nettype wire

/* File: rtl/cet_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module cet_capture
	import cet_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [CET_AW-1:0] i_addr,
	input wire logic [CET_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [CET_DW-1:0] o_rdata,
	input wire logic [CET_TW-1:0] i_timer_count,
	input wire logic i_pin,
	output logic o_pin,
	output logic o_pin_oe_n,
	input wire logic i_comparator_one_synced_out,
	input wire logic i_comparator_two_synced_out,
	input wire logic i_pin_change_trigger,
	output logic o_irq
);

	cet_ctrl_t ctrl_q;
	logic [1:0] src_q;
	cet_value_t value_q;
	logic flag_q;
	logic irq_en_q;
	logic latch_q;
	logic dir_in_q;
	logic [CET_DW-1:0] rdata_q;
	logic [CET_DW-1:0] rdata_d;

	logic wr_ctrl;
	logic wr_src;
	logic wr_clr;
	logic wr_en;
	logic wr_pin;
	logic [3:0] new_mode;
	logic new_en;
	logic mode_change;
	logic pre_clr;

	logic pin_level;
	logic sel_level;
	logic rise;
	logic fall;
	logic [4:0] div;
	logic pre_tick;
	logic pre_hit;
	logic capture;

	// Register write decode
	assign wr_ctrl = i_wr & (i_addr == CET_ADDR_CTRL);
	assign wr_src = i_wr & (i_addr == CET_ADDR_SRC);
	assign wr_clr = i_wr & (i_addr == CET_ADDR_IRQ_CLR);
	assign wr_en = i_wr & (i_addr == CET_ADDR_IRQ_EN);
	assign wr_pin = i_wr & (i_addr == CET_ADDR_PIN);

	assign new_mode = i_wdata[CET_CTRL_MODE_LSB +: 4];
	assign new_en = i_wdata[CET_CTRL_EN_BIT];

	// Control register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q.en <= CET_RST_CTRL[CET_CTRL_EN_BIT];
			ctrl_q.mode <= CET_RST_CTRL[CET_CTRL_MODE_LSB +: 4];
		end else if (wr_ctrl) begin
			ctrl_q.en <= new_en;
			ctrl_q.mode <= new_mode;
		end
	end

	// Source select register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			src_q <= CET_RST_SRC;
		end else if (wr_src) begin
			src_q <= i_wdata[1:0];
		end
	end

	// Interrupt enable register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_en_q <= CET_RST_IRQ_EN[CET_IRQ_CAP_BIT];
		end else if (wr_en) begin
			irq_en_q <= i_wdata[CET_IRQ_CAP_BIT];
		end
	end

	// Pin latch and direction
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			latch_q <= CET_RST_LATCH;
			dir_in_q <= CET_RST_DIR_IN;
		end else if (wr_pin) begin
			latch_q <= i_wdata[CET_PIN_LATCH_BIT];
			dir_in_q <= i_wdata[CET_PIN_DIR_BIT];
		end
	end

	// Pin drive; the enable is low while the pin is driven
	assign o_pin = latch_q;
	assign o_pin_oe_n = dir_in_q;

	// An output pin reads back its own latch, so latch writes act as input events
	assign pin_level = dir_in_q ? i_pin : latch_q;

	// Capture input selection
	always_comb begin
		case (src_q)
			CET_SRC_PIN: sel_level = pin_level;
			CET_SRC_CMP1: sel_level = i_comparator_one_synced_out;
			CET_SRC_CMP2: sel_level = i_comparator_two_synced_out;
			CET_SRC_CHG: sel_level = i_pin_change_trigger;
			default: sel_level = pin_level;
		endcase
	end

	cet_edge u_edge (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(sel_level),
		.o_rise(rise),
		.o_fall(fall)
	);

	// Prescaler restart on a mode change or on disable
	assign mode_change = wr_ctrl & (new_mode != ctrl_q.mode);
	assign pre_clr = mode_change | ~ctrl_q.en | (wr_ctrl & ~new_en);

	assign div = (ctrl_q.mode == CET_MODE_RISE16) ? CET_DIV16 : CET_DIV4;
	assign pre_tick = rise & ((ctrl_q.mode == CET_MODE_RISE4) | (ctrl_q.mode == CET_MODE_RISE16));

	cet_prescale u_prescale (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clr(pre_clr),
		.i_tick(pre_tick),
		.i_div(div),
		.o_hit(pre_hit)
	);

	// Event qualification
	always_comb begin
		capture = 1'b0;
		if (ctrl_q.en) begin
			case (ctrl_q.mode)
				CET_MODE_ANY: capture = rise | fall;
				CET_MODE_FALL: capture = fall;
				CET_MODE_RISE: capture = rise;
				CET_MODE_RISE4: capture = pre_hit & ~pre_clr;
				CET_MODE_RISE16: capture = pre_hit & ~pre_clr;
				default: capture = 1'b0;
			endcase
		end
	end

	// Captured timer value, overwritten by each new capture
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			value_q <= '0;
		end else if (capture) begin
			value_q.high <= i_timer_count[CET_TW-1:CET_DW];
			value_q.low <= i_timer_count[CET_DW-1:0];
		end
	end

	// Sticky capture flag; a capture beats a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else if (capture) begin
			flag_q <= 1'b1;
		end else if (wr_clr & i_wdata[CET_IRQ_CAP_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	assign o_irq = flag_q & irq_en_q;

	// Read mux
	always_comb begin
		rdata_d = CET_RD_ZERO;
		if (i_rd) begin
			case (i_addr)
				CET_ADDR_CTRL: begin
					rdata_d[CET_CTRL_EN_BIT] = ctrl_q.en;
					rdata_d[CET_CTRL_MODE_LSB +: 4] = ctrl_q.mode;
				end
				CET_ADDR_SRC: rdata_d[1:0] = src_q;
				CET_ADDR_VAL_LOW: rdata_d = value_q.low;
				CET_ADDR_VAL_HIGH: rdata_d = value_q.high;
				CET_ADDR_IRQ_STAT: rdata_d[CET_IRQ_CAP_BIT] = flag_q;
				CET_ADDR_IRQ_EN: rdata_d[CET_IRQ_CAP_BIT] = irq_en_q;
				CET_ADDR_PIN: begin
					rdata_d[CET_PIN_LATCH_BIT] = latch_q;
					rdata_d[CET_PIN_DIR_BIT] = dir_in_q;
				end
				default: rdata_d = CET_RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= CET_RD_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

endmodule : cet_capture
`default_nettype wire

/* File: tb/cet_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cet_src_model (
	input wire logic [3:0] i_lvl,
	input wire logic i_pin_out,
	input wire logic i_pin_oe_n,
	output logic o_pin,
	output logic o_cmp1,
	output logic o_cmp2,
	output logic o_chg
);
	// Pin wire follows the device while it drives
	assign o_pin = i_pin_oe_n ? i_lvl[0] : i_pin_out;
	assign o_cmp1 = i_lvl[1];
	assign o_cmp2 = i_lvl[2];
	assign o_chg = i_lvl[3];
endmodule : cet_src_model
`default_nettype wire

/* File: tb/cet_capture_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cet_capture_props
	import cet_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [CET_AW-1:0] i_addr,
	input wire logic [CET_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [CET_DW-1:0] o_rdata,
	input wire logic o_pin,
	input wire logic o_pin_oe_n,
	input wire logic o_irq
);
	logic en_q;
	wire logic irq_wr;
	assign irq_wr = i_wr && (i_addr == CET_ADDR_IRQ_CLR || i_addr == CET_ADDR_IRQ_EN);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			en_q <= 1'b0;
		end else if (i_wr && i_addr == CET_ADDR_CTRL) begin
			en_q <= i_wdata[CET_CTRL_EN_BIT];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_pin_wr;
		i_wr && i_addr == CET_ADDR_PIN;
	endsequence
	sequence s_cap_seen;
		$rose(o_irq) && !$past(i_wr);
	endsequence
	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == CET_RD_ZERO)
		else $error("read data not idle");
	AST_FLAG_HOLDS: assert property (o_irq && !irq_wr |=> o_irq)
		else $error("flag dropped without clear");
	AST_STAT_FLAG: assert property (o_irq && i_rd && i_addr == CET_ADDR_IRQ_STAT |=> o_rdata[0])
		else $error("status misses flag");
	AST_PIN_WRITE: assert property (s_pin_wr |=> o_pin == $past(i_wdata[0]) && o_pin_oe_n == $past(i_wdata[1]))
		else $error("pin outputs wrong");
	AST_PIN_HOLD: assert property (!(i_wr && i_addr == CET_ADDR_PIN) |=> $stable(o_pin) && $stable(o_pin_oe_n))
		else $error("pin outputs moved");
	AST_CAP_NEEDS_EN: assert property (s_cap_seen |-> $past(en_q))
		else $error("capture while disabled");
	AST_IRQ_MASK: assert property (i_wr && i_addr == CET_ADDR_IRQ_EN && !i_wdata[0] |=> !o_irq)
		else $error("masked irq high");
	AST_CLR_READ: assert property (i_rd && i_addr == CET_ADDR_IRQ_CLR |=> o_rdata == CET_RD_ZERO)
		else $error("clear register readable");
endmodule : cet_capture_props
bind cet_capture cet_capture_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin(o_pin),
	.o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq));
`default_nettype wire

/* File: tb/tb_capture_event_timestamp.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_capture_event_timestamp
	import cet_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] addr = '0;
	logic [7:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] timer = '0;
	logic [3:0] lvl = '0;
	logic [7:0] exp_cnt [5] = '{8'h20, 8'h10, 8'h10, 8'h04, 8'h01};
	wire logic [7:0] rdata;
	wire logic pin, pin_o, pin_oe_n, cmp1, cmp2, chg, irq;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int cnt;
	always #50 i_clk = ~i_clk;
	cet_capture dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_timer_count(timer), .i_pin(pin), .o_pin(pin_o),
		.o_pin_oe_n(pin_oe_n), .i_comparator_one_synced_out(cmp1),
		.i_comparator_two_synced_out(cmp2), .i_pin_change_trigger(chg), .o_irq(irq));
	cet_src_model u_src (.i_lvl(lvl), .i_pin_out(pin_o), .i_pin_oe_n(pin_oe_n), .o_pin(pin),
		.o_cmp1(cmp1), .o_cmp2(cmp2), .o_chg(chg));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		@(negedge i_clk);
		v = rdata;
	endtask : rd_reg
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_reg(a, v);
		chk(v, exp);
	endtask : rd_chk
	task automatic setl(input int i, input logic v);
		@(posedge i_clk);
		lvl <= (lvl & ~(4'h1 << i)) | ({3'h0, v} << i);
	endtask : setl
	task automatic pairs(input int i, input int n);
		logic [7:0] s;
		repeat (2 * n) begin
			setl(i, ~lvl[i]);
			rd_reg(CET_ADDR_IRQ_STAT, s);
			if (s[0] === 1'b1) begin
				cnt++;
				wr_reg(CET_ADDR_IRQ_CLR, 8'h01);
			end
		end
	endtask : pairs
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(CET_ADDR_CTRL, CET_RST_CTRL);
		rd_chk(CET_ADDR_PIN, 8'h02);
		rd_chk(4'hF, 8'h00);
		$display("test reset done");
		wr_reg(CET_ADDR_IRQ_EN, 8'h01);
		wr_reg(CET_ADDR_SRC, 8'h01);
		timer <= 16'hA5C3;
		wr_reg(CET_ADDR_CTRL, 8'h82);
		setl(1, 1'b1);
		rd_chk(CET_ADDR_VAL_LOW, 8'hC3);
		rd_chk(CET_ADDR_VAL_HIGH, 8'hA5);
		chk({7'h00, irq}, 8'h01);
		setl(1, 1'b0);
		timer <= 16'h1234;
		setl(1, 1'b1);
		repeat (20) @(posedge i_clk);
		rd_chk(CET_ADDR_VAL_LOW, 8'h34);
		rd_chk(CET_ADDR_VAL_HIGH, 8'h12);
		rd_chk(CET_ADDR_IRQ_STAT, 8'h01);
		wr_reg(CET_ADDR_IRQ_CLR, 8'h01);
		rd_chk(CET_ADDR_IRQ_STAT, 8'h00);
		rd_chk(CET_ADDR_IRQ_CLR, 8'h00);
		setl(1, 1'b0);
		$display("test capture done");
		wr_reg(CET_ADDR_PIN, 8'h02);
		for (int m = 0; m < 5; m++) begin
			wr_reg(CET_ADDR_SRC, 8'(m % 4));
			wr_reg(CET_ADDR_CTRL, 8'h80 | 8'(m));
			cnt = 0;
			pairs(m % 4, 16);
			chk(8'(cnt), exp_cnt[m]);
		end
		$display("test modes done");
		wr_reg(CET_ADDR_CTRL, 8'h83);
		cnt = 0;
		pairs(0, 2);
		wr_reg(CET_ADDR_CTRL, 8'h03);
		wr_reg(CET_ADDR_CTRL, 8'h83);
		pairs(0, 3);
		chk(8'(cnt), 8'h00);
		pairs(0, 1);
		chk(8'(cnt), 8'h01);
		wr_reg(CET_ADDR_CTRL, 8'h85);
		cnt = 0;
		pairs(0, 2);
		chk(8'(cnt), 8'h00);
		$display("test prescale done");
		wr_reg(CET_ADDR_PIN, 8'h00);
		wr_reg(CET_ADDR_CTRL, 8'h82);
		wr_reg(CET_ADDR_PIN, 8'h01);
		rd_chk(CET_ADDR_IRQ_STAT, 8'h01);
		chk({6'h00, pin_oe_n, pin_o}, 8'h01);
		wr_reg(CET_ADDR_IRQ_EN, 8'h00);
		@(negedge i_clk);
		chk({7'h00, irq}, 8'h00);
		$display("test pin done");
		report_and_stop();
	end
endmodule : tb_capture_event_timestamp
`default_nettype wire
